//--- rtl/spi_host_slave_port.sv
// ============================================================
// serial host-access port with interrupt request pin
// assumes all serial pins are asynchronous to mclk; sclk period >= 80 ns
`timescale 1ns/1ps
module spi_host_slave_port
  import spi_port_pkg::*;
(
  input  wire  logic        mclk,         // 200 MHz system clock
  input  wire  logic        rst_n,        // synchronous reset, active low
  input  wire  logic        wb_cyc_i,     // wishbone cycle
  input  wire  logic        wb_stb_i,     // wishbone strobe
  input  wire  logic        wb_we_i,      // wishbone write
  input  wire  logic [7:0]  wb_adr_i,     // byte address
  input  wire  logic [3:0]  wb_sel_i,     // byte lanes
  input  wire  logic [31:0] wb_dat_i,     // write data
  output logic       [31:0] wb_dat_o,     // read data
  output logic              wb_ack_o,     // acknowledge
  input  wire  logic        cs_n,         // chip select pin, active low
  input  wire  logic        sclk,         // serial clock pin from master
  input  wire  logic        sdi,          // serial data in
  output logic              sdo_o,        // serial data out level
  output logic              sdo_oe_n,     // serial out enable, low = driving
  input  wire  logic        cpha,         // clock phase strap
  input  wire  logic        cpol,         // clock polarity strap
  output logic              irq_pin_o,    // interrupt_request_pin level
  output logic              irq_pin_oe_n  // interrupt_request_pin enable, low = driving
);
  import spi_port_pkg::*;

  // ============================================================
  // pin synchronisers
  logic [1:0] cs_sync_q, sclk_sync_q, sdi_sync_q, cpha_sync_q, cpol_sync_q;
  logic       sclk_old_q;
  logic       cs_act, sclk_s, sdi_s, cpha_s, cpol_s;

  // two flops per pin, then one more for sclk edge finding
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_sync_q   <= 2'h3;
      sclk_sync_q <= 2'h0;
      sdi_sync_q  <= 2'h0;
      cpha_sync_q <= 2'h0;
      cpol_sync_q <= 2'h0;
      sclk_old_q  <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      sclk_sync_q <= {sclk_sync_q[0], sclk};
      sdi_sync_q  <= {sdi_sync_q[0], sdi};
      cpha_sync_q <= {cpha_sync_q[0], cpha};
      cpol_sync_q <= {cpol_sync_q[0], cpol};
      sclk_old_q  <= sclk_sync_q[1];
    end
  end

  assign cs_act = !cs_sync_q[1];
  assign sclk_s = sclk_sync_q[1];
  assign sdi_s  = sdi_sync_q[1];
  assign cpha_s = cpha_sync_q[1];
  assign cpol_s = cpol_sync_q[1];

  // ============================================================
  // edge classification
  logic edge_any, lead_edge, trail_edge, sample_edge, shift_edge;

  // leading edge leaves the idle level, trailing edge returns to it
  assign edge_any    = sclk_s != sclk_old_q;
  assign lead_edge   = edge_any && (sclk_old_q == cpol_s);
  assign trail_edge  = edge_any && (sclk_old_q != cpol_s);
  assign sample_edge = cpha_s ? trail_edge : lead_edge;
  assign shift_edge  = cpha_s ? lead_edge : trail_edge;

  // ============================================================
  // serial engine
  logic [4:0]  cnt_q;
  logic [15:0] rx_q;
  logic [7:0]  rd_q;
  logic        sdo_q;
  logic        cs_act_q;
  logic [7:0]  mbox_q [4];
  logic [EVT_W-1:0] evt;
  logic        frame_done;

  // bit that belongs at serial position idx; command phase sends zeros
  function automatic logic frame_bit(input logic [4:0] idx, input logic [7:0] data);
    logic [2:0] pos;
    pos = 3'(5'h0f - idx);
    frame_bit = (idx >= CMD_BITS) ? data[pos] : 1'b0;
  endfunction

  assign frame_done = cs_act && sample_edge && (cnt_q == FRAME_BITS - 5'h01);

  // bit counter and receive shifter; chip select high restarts the frame
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      rx_q  <= 16'h0000;
    end else if (!cs_act) begin
      cnt_q <= 5'h00;
    end else if (sample_edge && cnt_q < FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h01;
      rx_q  <= {rx_q[14:0], sdi_s};
    end
  end

  // read data fetched once the command byte is complete
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else if (cs_act && sample_edge && cnt_q == CMD_BITS - 5'h01) begin
      // a read command loads the addressed mailbox byte, a write command sends zeros
      rd_q <= rx_q[CMD_RD_BIT-1] ? mbox_q[{rx_q[0], sdi_s}] : 8'h00;
    end
  end

  // output shifter; phase 0 presents bit 0 as soon as the frame opens
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdo_q    <= 1'b0;
      cs_act_q <= 1'b0;
    end else begin
      cs_act_q <= cs_act;
      if (cs_act && !cs_act_q) begin
        sdo_q <= 1'b0;
      end else if (cs_act && shift_edge) begin
        sdo_q <= frame_bit(cnt_q, rd_q);
      end
    end
  end

  assign sdo_o    = sdo_q;
  assign sdo_oe_n = !cs_act_q;

  // serial events
  always_comb begin
    evt            = '0;
    evt[EVT_WR]    = frame_done && !rx_q[14];
    evt[EVT_RD]    = frame_done && rx_q[14];
    evt[EVT_ABORT] = !cs_act && cs_act_q && cnt_q != 5'h00 && cnt_q != FRAME_BITS;
  end

  // ============================================================
  // wishbone slave and registers
  logic             wb_req, wb_wr, mbox_hit;
  logic [1:0]       mbox_idx;
  irq_cfg_t         cfg_q;
  logic [EVT_W-1:0] stat_q, en_q, wb_clr;
  logic [31:0]      rdat;

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
  assign mbox_hit = wb_adr_i >= OFS_MBOX_BASE && wb_adr_i <= OFS_MBOX_LAST && wb_adr_i[1:0] == 2'h0;
  assign mbox_idx = wb_adr_i[3:2];
  assign wb_clr   = (wb_wr && wb_adr_i == OFS_IRQ_CLR) ? wb_dat_i[EVT_W-1:0] : '0;

  // one-cycle acknowledge for every address, mapped or not
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? rdat : 32'h0000_0000;
    end
  end

  // read multiplexer; clear register and holes read zero
  always_comb begin
    rdat = 32'h0000_0000;
    case (wb_adr_i)
      OFS_IRQ_CFG:  rdat[3:0]       = cfg_q;
      OFS_IRQ_STAT: rdat[EVT_W-1:0] = stat_q;
      OFS_IRQ_EN:   rdat[EVT_W-1:0] = en_q;
      default:      if (mbox_hit) rdat[7:0] = mbox_q[mbox_idx];
    endcase
  end

  // configuration and enable registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= IRQ_CFG_RST;
      en_q  <= IRQ_EN_RST;
    end else if (wb_wr && wb_adr_i == OFS_IRQ_CFG) begin
      cfg_q <= wb_dat_i[3:0];
    end else if (wb_wr && wb_adr_i == OFS_IRQ_EN) begin
      en_q <= wb_dat_i[EVT_W-1:0];
    end
  end

  // mailbox: a serial write wins over a bus write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) mbox_q[i] <= 8'h00;
    end else if (evt[EVT_WR]) begin
      // index is the low two bits of the command byte, already shifted up by seven
      mbox_q[rx_q[8:7]] <= {rx_q[6:0], sdi_s};
    end else if (wb_wr && mbox_hit) begin
      mbox_q[mbox_idx] <= wb_dat_i[7:0];
    end
  end

  // sticky status; a new event beats a simultaneous clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~wb_clr) | evt;
    end
  end

  // ============================================================
  // interrupt request pin
  logic irq_any, pin_level;

  assign irq_any   = |(stat_q & en_q);
  assign pin_level = cfg_q.gpo_mode ? cfg_q.gpo_val
                                    : (irq_any == cfg_q.active_high);
  // open drain drives only low and floats for high
  assign irq_pin_o    = cfg_q.open_drain ? 1'b0 : pin_level;
  assign irq_pin_oe_n = cfg_q.open_drain ? pin_level : 1'b0;

  // ============================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_cut;
    cs_act_q && !cs_act && cnt_q != 5'h00 && cnt_q < FRAME_BITS;
  endsequence

  a_idle_count_zero: assert property (!cs_act |=> cnt_q == 5'h00)
    else $error("bit counter not cleared while deselected");
  a_sdo_float_idle: assert property (!cs_act ##1 !cs_act |-> sdo_oe_n)
    else $error("serial output driven while deselected");
  a_rx_takes_sdi: assert property (cs_act && sample_edge && cnt_q < FRAME_BITS |=> rx_q[0] == $past(sdi_s))
    else $error("sampled bit not shifted in");
  a_lead_from_idle: assert property (lead_edge |-> sclk_s != cpol_s && $past(sclk_s) == cpol_s)
    else $error("leading edge not leaving idle level");
  a_phase_sample: assert property (cs_act && cnt_q < FRAME_BITS && (cpha_s ? trail_edge : lead_edge) |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("sample taken on wrong edge");
  a_irq_polarity: assert property (!cfg_q.gpo_mode && !cfg_q.open_drain |-> irq_pin_o == (irq_any ~^ cfg_q.active_high))
    else $error("request level has wrong polarity");
  a_open_drain: assert property (cfg_q.open_drain |-> !irq_pin_o && (irq_pin_oe_n == pin_level))
    else $error("open drain pin drives high");
  a_gpo_mode: assert property (cfg_q.gpo_mode && !cfg_q.open_drain |-> irq_pin_o == cfg_q.gpo_val)
    else $error("general output level wrong");
  a_abort_flag: assert property (s_frame_cut |=> stat_q[EVT_ABORT] ##1 cnt_q == 5'h00)
    else $error("aborted frame not flagged");
  a_sdo_read_bit: assert property (cs_act && cs_act_q && shift_edge && cnt_q == 5'h08 |=> sdo_q == rd_q[7])
    else $error("first read bit wrong");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

//--- rtl/spi_port_pkg.sv
// ============================================================
// package for the serial host-access port
// assumes a 32-bit classic wishbone bus and a 200 MHz mclk
package spi_port_pkg;

  // ============================================================
  // register byte offsets
  localparam logic [7:0] OFS_IRQ_CFG   = 8'h00;  // interrupt_config_register
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;  // sticky event status, read only
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h08;  // write one to clear, write only
  localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;  // event enable
  localparam logic [7:0] OFS_MBOX_BASE = 8'h10;  // four mailbox bytes, one per word
  localparam logic [7:0] OFS_MBOX_LAST = 8'h1c;

  // ============================================================
  // field positions and reset values
  localparam int EVT_WR    = 0;  // serial write finished
  localparam int EVT_RD    = 1;  // serial read finished
  localparam int EVT_ABORT = 2;  // frame cut short by chip select
  localparam int EVT_W     = 3;
  localparam logic [3:0] IRQ_CFG_RST = 4'h1;  // active high, push-pull, irq mode
  localparam logic [2:0] IRQ_EN_RST  = 3'h0;

  // ============================================================
  // serial frame layout: command byte then data byte, msb first
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam int         CMD_RD_BIT = 7;  // 1 = read, 0 = write

  typedef struct packed {
    logic gpo_val;      // level driven in general-purpose mode
    logic gpo_mode;     // pin acts as plain output
    logic open_drain;   // drive only the low level
    logic active_high;  // polarity of the request
  } irq_cfg_t;

endpackage

//--- verif/spi_master_model.sv
// serial bus master model for the host-access port
// assumes mclk at 200 MHz; one serial half period is 8 mclk (80 ns period)
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic mclk,      // bench clock, paces the serial clock
  input  wire logic cpol,      // clock polarity strap
  input  wire logic cpha,      // clock phase strap
  input  wire logic sdo_o,     // device serial out level
  input  wire logic sdo_oe_n,  // device serial out enable, low = driving
  output logic      cs_n,      // chip select, active low
  output logic      sclk,      // serial clock, only this side drives it
  output logic      sdi        // serial data toward the device
);
  // ============================================================
  // idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ============================================================
  // one frame, msb first; sel=0 sends clocks with chip select held high
  task automatic xfer(input logic sel, input logic [15:0] tx, input int nb, output logic [7:0] rx);
    logic b;
    b  = 1'b0;
    rx = 8'h00;
    sclk <= cpol;
    gap(4);
    cs_n <= ~sel;
    gap(8);
    for (int i = 15; i > 15 - nb; i--) begin
      if (!cpha) sdi <= tx[i];
      gap(8);
      if (!cpha) b = sdo_oe_n ? ~b : sdo_o;
      sclk <= ~cpol;
      if (cpha) sdi <= tx[i];
      gap(8);
      if (cpha) b = sdo_oe_n ? ~b : sdo_o;
      sclk <= cpol;
      rx = {rx[6:0], b};
    end
    gap(8);
    cs_n <= 1'b1;
    // released data line toggles so a stale bit cannot pass
    sdi  <= ~sdi;
    gap(6);
  endtask
endmodule

//--- verif/spi_host_slave_port_test.sv
// self-checking bench for the serial host-access port
// assumes the design asserts internally; master model drives the pins
`timescale 1ns/1ps
module spi_host_slave_port_test;
  import spi_port_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        ack, cs_n, sclk, sdi, sdo_o, sdo_oe_n, cpha = 1'b0, cpol = 1'b0;
  logic        pin_o, pin_oe_n;
  logic [7:0]  rx;
  int          failures = 0, total_checks = 0, cycles = 0;
  typedef struct packed {logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} row_t;
  localparam row_t ROWS [9] = '{
    '{8'h00, 4'hf, 32'hffff_fff5, 32'h5}, '{8'h0c, 4'hf, 32'hff, 32'h7}, '{8'h10, 4'hf, 32'h1234_56a1, 32'ha1},
    '{8'h14, 4'hf, 32'h5e, 32'h5e}, '{8'h18, 4'hf, 32'hc3, 32'hc3}, '{8'h18, 4'he, 32'h11, 32'hc3},
    '{8'h08, 4'hf, 32'hff, 32'h0}, '{8'h04, 4'hf, 32'hff, 32'h0}, '{8'h20, 4'hf, 32'hff, 32'h0}};
  localparam logic [8:0] IRQ_ROWS [9] = '{9'h026, 9'h028, 9'h004, 9'h00a, 9'h065, 9'h044, 9'h049, 9'h084, 9'h182};

  always #2.5 mclk = ~mclk;

  spi_host_slave_port u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .cpha(cpha), .cpol(cpol),
    .irq_pin_o(pin_o), .irq_pin_oe_n(pin_oe_n));
  spi_master_model u_master (.mclk(mclk), .cpol(cpol), .cpha(cpha), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  task print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ============================================================
  // timeout guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      print_verdict;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // classic single wishbone cycle; read data lands in rd
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge mclk);
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // ============================================================
  // main sequence
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      wb(1'b1, ROWS[i].a, ROWS[i].s, ROWS[i].d);
      wb(1'b0, ROWS[i].a, 4'hf, 32'h0);
      chk("reg", ROWS[i].e, rd);
    end
    do_reset();
    wb(1'b0, OFS_IRQ_CFG, 4'hf, 32'h0);
    chk("cfg_rst", 32'h1, rd);
    chk("pins_rst", 32'h0, {pin_o, pin_oe_n, sdo_oe_n}  ^ 32'h1);
    for (int m = 0; m < 4; m++) begin
      cpol <= m[1];
      cpha <= m[0];
      @(posedge mclk);
      u_master.xfer(1'b1, {8'h00 | 8'(m), 8'h3c + 8'(m)}, 16, rx);
      u_master.xfer(1'b1, {8'h80 | 8'(m), 8'h00}, 16, rx);
      chk("sdo_byte", 32'h3c + m, {24'h0, rx});
      wb(1'b0, OFS_MBOX_BASE + 8'(4 * m), 4'hf, 32'h0);
      chk("mbox", 32'h3c + m, rd);
    end
    chk("oe_idle", 32'h1, {31'h0, sdo_oe_n});
    wb(1'b0, OFS_IRQ_STAT, 4'hf, 32'h0);
    chk("stat", 32'h3, rd);
    wb(1'b1, OFS_IRQ_CLR, 4'hf, 32'h7);
    u_master.xfer(1'b0, 16'h00ff, 16, rx);
    wb(1'b0, OFS_MBOX_BASE, 4'hf, 32'h0);
    chk("ignored", 32'h3c, rd);
    u_master.xfer(1'b1, 16'h00ff, 5, rx);
    u_master.xfer(1'b1, 16'h0099, 16, rx);
    wb(1'b0, OFS_MBOX_BASE, 4'hf, 32'h0);
    chk("after_abort", 32'h99, rd);
    wb(1'b0, OFS_IRQ_STAT, 4'hf, 32'h0);
    chk("stat_abort", 32'h5, rd);
    foreach (IRQ_ROWS[i]) begin
      wb(1'b1, OFS_IRQ_CFG, 4'hf, {28'h0, IRQ_ROWS[i][8:5]});
      wb(1'b1, OFS_IRQ_EN, 4'hf, {29'h0, IRQ_ROWS[i][4:2]});
      chk("irq_pin", {30'h0, IRQ_ROWS[i][1:0]}, {30'h0, pin_o, pin_oe_n});
    end
    wb(1'b1, OFS_IRQ_CFG, 4'hf, 32'h1);
    wb(1'b1, OFS_IRQ_EN, 4'hf, 32'h7);
    wb(1'b1, OFS_IRQ_CLR, 4'hf, 32'h7);
    chk("irq_clr", 32'h0, {30'h0, pin_o, pin_oe_n});
    print_verdict;
  end
endmodule
